//--- pkg/sas_pkg.sv
// constants shared by the converter sequencer
package sas_pkg;
    // register byte addresses on the apb bus
    localparam logic [7:0] ADDR_CONVERTER_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PIN_REF_CFG    = 8'h04;
    localparam logic [7:0] ADDR_CLOCK_FORMAT   = 8'h08;
    localparam logic [7:0] ADDR_RESULT_HIGH    = 8'h0C;
    localparam logic [7:0] ADDR_RESULT_LOW     = 8'h10;
    localparam logic [7:0] ADDR_STATUS         = 8'h14;
    // converter control fields
    localparam int CTRL_ON_BIT   = 0;
    localparam int CTRL_GO_BIT   = 1;
    localparam int CTRL_CHAN_LSB = 2;
    // pin/reference config fields
    localparam int CFG_PORT_LSB = 0;
    localparam int CFG_REF_LSB  = 4;
    // clock/format fields
    localparam int FMT_ALIGN_BIT = 7;
    localparam int FMT_CLK_LSB   = 0;
    // status fields
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_IEN_BIT  = 1;
    // reset values
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam logic [5:0] CFG_RESET  = 6'h00;
    localparam logic [3:0] FMT_RESET  = 4'h0;
    // conversion timing in bit periods
    localparam int CONV_PERIODS = 12;
    localparam int WAIT_PERIODS = 2;
    localparam int RESULT_BITS  = 10;
    // internal rc clock: 1 MHz maximum, derived from the 100 ns system clock
    localparam int SYS_PERIOD_NS = 100;
    localparam int RC_PERIOD_NS  = 1000;
    localparam int RC_DIV        = (RC_PERIOD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    // sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CONV = 4'b0010,
        ST_WAIT = 4'b0100,
        ST_DONE = 4'b1000
    } sas_state_t;
endpackage : sas_pkg

//--- core/sas_tick_gen.sv
// bit period tick generator from oscillator divide or internal rc clock
`timescale 1ns/10ps
`default_nettype none
module sas_tick_gen
    import sas_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       clkEn,
    input  wire logic       sleepMode,
    input  wire logic [2:0] clockSelect,
    input  wire logic       run,
    output logic            bitTick
);
    logic [6:0] divCount;
    logic [6:0] divLimit;
    logic       rcSelected;

    // decode the select code into a terminal count one less than the divide
    // clock code decode
    always_comb begin
        rcSelected = (clockSelect[1:0] == 2'b11);
        case (clockSelect)
            3'b000:  divLimit = 7'h01;
            3'b001:  divLimit = 7'h07;
            3'b010:  divLimit = 7'h1F;
            3'b100:  divLimit = 7'h03;
            3'b101:  divLimit = 7'h0F;
            3'b110:  divLimit = 7'h3F;
            default: divLimit = 7'(RC_DIV - 1);
        endcase
    end

    // oscillator divisions stop in sleep; only the rc source keeps ticking
    // sleep gating
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !run) begin
            divCount <= 7'h00;
            bitTick  <= 1'b0;
        end else if (clkEn) begin
            if (sleepMode && !rcSelected) begin
                bitTick <= 1'b0;
            end else if (divCount >= divLimit) begin
                divCount <= 7'h00;
                bitTick  <= 1'b1;
            end else begin
                divCount <= divCount + 7'h01;
                bitTick  <= 1'b0;
            end
        end
    end
endmodule : sas_tick_gen
`default_nettype wire

//--- core/sar_adc_sequencer.sv
// successive approximation converter sequencer with apb registers
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module sar_adc_sequencer
    import sas_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        clkEn,
    input  wire logic        sleepMode,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        compHigh,
    output logic      [9:0]  dacCode,
    output logic             sampleHold,
    output logic      [3:0]  channelSelect,
    output logic      [1:0]  referenceSelect,
    output logic      [15:0] analogPinEnable,
    output logic             irqRequest
);
    logic [5:0]  converterCtrl;
    logic [5:0]  pinRefCfg;
    logic [3:0]  clockFormat;
    logic [7:0]  resultHigh;
    logic [7:0]  resultLow;
    logic        doneFlag;
    logic        irqEnable;
    sas_state_t  state;
    logic [3:0]  periodCount;
    logic [9:0]  trialCode;
    logic        compSync1;
    logic        compSync2;
    logic        bitTick;
    logic        wrEn;
    logic        rdEn;
    logic        addrHit;
    logic        goWrite;
    logic        goClear;
    logic        convDone;
    logic [15:0] rightResult;
    logic [15:0] leftResult;
    logic [31:0] next_prdata;
    logic [4:0]  digitalCount;

    // bus strobes; single access cycle so pready can stay high
    assign wrEn    = psel && penable && pwrite && clkEn;
    // read data is captured in the setup cycle and stands through the access phase
    assign rdEn    = psel && !penable && !pwrite;
    assign goWrite = wrEn && (paddr == ADDR_CONVERTER_CTRL);
    assign goClear = goWrite && !pwdata[CTRL_GO_BIT];
    assign convDone = (state == ST_CONV) && bitTick && (periodCount == 4'(CONV_PERIODS - 1));

    // comparator comes from the analog side, so synchronise it
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            compSync1 <= 1'b0;
            compSync2 <= 1'b0;
        end else if (clkEn) begin
            compSync1 <= compHigh;
            compSync2 <= compSync1;
        end
    end

    // bit period source, sleep gating inside
    // the comparator path is three cycles deep, so a divide-by-2 bit period
    // decides on a stale comparison; that code is faster than the converter allows
    sas_tick_gen u_tick (
        .sys_clk     (sys_clk),
        .sys_rst     (sys_rst),
        .clkEn       (clkEn),
        .sleepMode   (sleepMode),
        .clockSelect (clockFormat[FMT_CLK_LSB +: 3]),
        .run         (state != ST_IDLE),
        .bitTick     (bitTick)
    );

    // converter control register; go is hardware cleared on completion
    // switching the converter off drops go, which aborts the sequencer
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            converterCtrl <= CTRL_RESET;
        end else if (clkEn) begin
            if (goWrite) begin
                converterCtrl[CTRL_ON_BIT] <= pwdata[CTRL_ON_BIT];
                converterCtrl[CTRL_CHAN_LSB +: 4] <= pwdata[CTRL_CHAN_LSB +: 4];
                // go only while enabled, and never in the enabling write
                converterCtrl[CTRL_GO_BIT] <= pwdata[CTRL_GO_BIT] && converterCtrl[CTRL_ON_BIT]
                                              && pwdata[CTRL_ON_BIT];
            end else if (convDone || !converterCtrl[CTRL_ON_BIT]) begin
                converterCtrl[CTRL_GO_BIT] <= 1'b0;
            end
        end
    end

    // configuration registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pinRefCfg   <= CFG_RESET;
            clockFormat <= FMT_RESET;
            irqEnable   <= 1'b0;
        end else if (wrEn) begin
            if (paddr == ADDR_PIN_REF_CFG)
                pinRefCfg <= pwdata[5:0];
            if (paddr == ADDR_CLOCK_FORMAT)
                clockFormat <= {pwdata[FMT_ALIGN_BIT], pwdata[FMT_CLK_LSB +: 3]};
            if (paddr == ADDR_STATUS)
                irqEnable <= pwdata[STAT_IEN_BIT];
        end
    end

    // done flag: hardware set wins over a software clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            doneFlag <= 1'b0;
        end else if (clkEn) begin
            if (convDone)
                doneFlag <= 1'b1;
            else if (wrEn && paddr == ADDR_STATUS && pwdata[STAT_DONE_BIT])
                doneFlag <= 1'b0;
        end
    end

    // result pair has no reset term
    always_ff @(posedge sys_clk) begin
        if (clkEn) begin
            if (convDone) begin
                resultHigh <= clockFormat[3] ? rightResult[15:8] : leftResult[15:8];
                resultLow  <= clockFormat[3] ? rightResult[7:0] : leftResult[7:0];
            end else if (wrEn && paddr == ADDR_RESULT_HIGH) begin
                resultHigh <= pwdata[7:0];
            end else if (wrEn && paddr == ADDR_RESULT_LOW) begin
                resultLow <= pwdata[7:0];
            end
        end
    end

    // final bit decided in period 10; the completing period adds no bit
    always_comb begin
        logic [9:0] finalCode;
        finalCode = compSync2 ? trialCode : (trialCode & ~(10'h200 >> (periodCount - 4'h1)));
        rightResult = {6'h00, finalCode};
        leftResult  = {finalCode, 6'h00};
    end

    // sequencer: twelve periods of conversion then a two period wait
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state       <= ST_IDLE;
            periodCount <= 4'h0;
            trialCode   <= 10'h000;
        end else if (clkEn) begin
            case (state)
                ST_IDLE: begin
                    periodCount <= 4'h0;
                    trialCode   <= 10'h200;
                    if (converterCtrl[CTRL_GO_BIT])
                        state <= ST_CONV;
                end
                ST_CONV: begin
                    // period 0 lets the held sample settle, period 11 finishes
                    // abort keeps the old result
                    if (goClear || !converterCtrl[CTRL_GO_BIT]) begin
                        state       <= ST_WAIT;
                        periodCount <= 4'h0;
                    end else if (bitTick) begin
                        if (periodCount == 4'(CONV_PERIODS - 1)) begin
                            state       <= ST_WAIT;
                            periodCount <= 4'h0;
                        end else begin
                            periodCount <= periodCount + 4'h1;
                            // periods 1..10 each resolve one bit, msb first
                            if (periodCount >= 4'h1 && periodCount <= 4'(RESULT_BITS)) begin
                                if (!compSync2)
                                    trialCode <= trialCode & ~(10'h200 >> (periodCount - 4'h1));
                                if (periodCount < 4'(RESULT_BITS))
                                    trialCode <= (compSync2 ? trialCode
                                                 : trialCode & ~(10'h200 >> (periodCount - 4'h1)))
                                                 | (10'h200 >> periodCount);
                            end
                        end
                    end
                end
                ST_WAIT: begin
                    // two bit periods before a new conversion can start; sampleHold is still high in the first cycle here and falls on the next edge
                    if (bitTick) begin
                        if (periodCount == 4'(WAIT_PERIODS - 1))
                            state <= ST_DONE;
                        else
                            periodCount <= periodCount + 4'h1;
                    end
                end
                // one spare cycle so a go written during the wait starts from idle
                ST_DONE: begin
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // number of pins turned digital from the top down; code 15 takes all
    always_comb begin
        digitalCount = 5'h00;
        if (pinRefCfg[3:0] == 4'hF)
            digitalCount = 5'h10;
        else if (pinRefCfg[3:0] != 4'h0)
            digitalCount = {1'b0, pinRefCfg[3:0]} + 5'h01;
    end

    // analog side outputs registered
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dacCode         <= 10'h000;
            sampleHold      <= 1'b0;
            channelSelect   <= 4'h0;
            referenceSelect <= 2'h0;
            analogPinEnable <= 16'hFFFF;
            irqRequest      <= 1'b0;
        end else if (clkEn) begin
            dacCode         <= trialCode;
            sampleHold      <= (state == ST_CONV);
            channelSelect   <= converterCtrl[CTRL_CHAN_LSB +: 4];
            referenceSelect <= pinRefCfg[CFG_REF_LSB +: 2];
            // per-pin analog enable, higher codes turn top pins digital
            for (int i = 0; i < 16; i++)
                analogPinEnable[i] <= (5'(i) < (5'h10 - digitalCount));
            // interrupt line is a level: done flag gated by its enable
            irqRequest      <= doneFlag && irqEnable;
        end
    end

    // read mux
    always_comb begin
        addrHit     = 1'b1;
        next_prdata = 32'h0000_0000;
        case (paddr)
            ADDR_CONVERTER_CTRL: next_prdata = {26'h0, converterCtrl};
            ADDR_PIN_REF_CFG:    next_prdata = {26'h0, pinRefCfg};
            ADDR_CLOCK_FORMAT:   next_prdata = {24'h0, clockFormat[3], 4'h0, clockFormat[2:0]};
            ADDR_RESULT_HIGH:    next_prdata = {24'h0, resultHigh};
            ADDR_RESULT_LOW:     next_prdata = {24'h0, resultLow};
            ADDR_STATUS:         next_prdata = {30'h0, irqEnable, doneFlag};
            default:             addrHit = 1'b0;
        endcase
    end

    // apb answer: zero wait states, error on unmapped address
    // pslverr comes from the setup cycle, so it stands through the access phase
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b1;
            pslverr <= 1'b0;
        end else begin
            pready  <= 1'b1;
            pslverr <= psel && !penable && !addrHit;
            if (rdEn)
                prdata <= next_prdata;
        end
    end
endmodule : sar_adc_sequencer
`default_nettype wire

//--- dv/sas_props.sv
// port-level assertion checker for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
module sas_props
    import sas_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic        clkEn,
    input wire logic        sleepMode,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        compHigh,
    input wire logic [9:0]  dacCode,
    input wire logic        sampleHold,
    input wire logic [3:0]  channelSelect,
    input wire logic [1:0]  referenceSelect,
    input wire logic [15:0] analogPinEnable,
    input wire logic        irqRequest
);
    logic        ctrlWr;
    logic        cfgWr;
    // writes qualified the way the core takes them
    assign ctrlWr = psel && penable && pwrite && clkEn && paddr == ADDR_CONVERTER_CTRL;
    assign cfgWr  = psel && penable && pwrite && clkEn && paddr == ADDR_PIN_REF_CFG;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    chk_reset_state: assert property ($fell(sys_rst) |-> !sampleHold && !irqRequest && channelSelect == 4'h0
        && analogPinEnable == 16'hFFFF) else $error("outputs not at reset values");
    chk_unmapped_err: assert property (psel && penable && paddr > ADDR_STATUS |-> pslverr)
        else $error("unmapped access without error");
    chk_fmt_zero: assert property (psel && penable && !pwrite && paddr == ADDR_CLOCK_FORMAT |->
        prdata[31:8] == 24'h0 && prdata[6:3] == 4'h0) else $error("clock format unused bits set");
    chk_chan_follow: assert property (ctrlWr |-> ##2 channelSelect == $past(pwdata[5:2], 2))
        else $error("channel select not updated");
    chk_ref_follow: assert property (cfgWr |-> ##2 referenceSelect == $past(pwdata[5:4], 2))
        else $error("reference select not updated");
    chk_pin_mask: assert property (cfgWr |-> ##2 analogPinEnable ==
        (($past(pwdata[3:0], 2) == 4'h0) ? 16'hFFFF : (16'h1 << (4'hF - $past(pwdata[3:0], 2))) - 16'h1))
        else $error("analog pin mask wrong");
    chk_abort_stop: assert property (ctrlWr && !pwdata[CTRL_GO_BIT] && sampleHold |-> ##[1:4] !sampleHold)
        else $error("conversion not aborted");
    chk_hold_start: assert property ($rose(sampleHold) |-> $past(ctrlWr, 1) || $past(ctrlWr, 2) ||
        $past(ctrlWr, 3) || $past(ctrlWr, 4)) else $error("hold without go write");
    cover property ($rose(sampleHold));
    cover property ($rose(irqRequest));
    cover property (pslverr);
endmodule : sas_props
bind sar_adc_sequencer sas_props i_props (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn), .sleepMode(sleepMode), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compHigh(compHigh), .dacCode(dacCode), .sampleHold(sampleHold), .channelSelect(channelSelect),
    .referenceSelect(referenceSelect), .analogPinEnable(analogPinEnable), .irqRequest(irqRequest));
`default_nettype wire

//--- dv/test_sar_adc_sequencer.sv
// self-checking bench for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
module test_sar_adc_sequencer
    import sas_pkg::*;
;
    logic        sys_clk, sys_rst, clkEn, sleepMode, psel, penable, pwrite, pready, pslverr;
    logic        compHigh, sampleHold, irqRequest, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0]  dacCode, target;
    logic [3:0]  channelSelect;
    logic [1:0]  referenceSelect;
    logic [15:0] analogPinEnable;
    int          cnt, badCount, checked;
    int          divs[8] = '{2, 8, 32, 10, 4, 16, 64, 10};
    logic [9:0]  tgts[8] = '{10'h000, 10'h3FF, 10'h2A5, 10'h15A, 10'h001, 10'h200, 10'h1FF, 10'h3FE};
    // input sits half a step above target, so the comparator never ties
    assign compHigh = (dacCode <= target);
    sar_adc_sequencer i_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn), .sleepMode(sleepMode), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .compHigh(compHigh), .dacCode(dacCode), .sampleHold(sampleHold), .channelSelect(channelSelect),
        .referenceSelect(referenceSelect), .analogPinEnable(analogPinEnable), .irqRequest(irqRequest));
    // free-running 100 ns clock
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            badCount++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic bail(input string what);
        badCount++;
        $display("ERROR %s wait ran out", what);
        finish_test();
    endtask : bail
    // one transfer; request held until pready is seen, then an idle edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        cnt = 0;
        do begin
            @(posedge sys_clk);
            cnt++;
        end while (pready !== 1'b1 && cnt < 16);
        if (pready !== 1'b1) bail("pready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    // bounded wait for the hold output; cnt ends as the edges waited
    task automatic waitHold(input logic lvl, input int lim);
        cnt = 0;
        while (sampleHold !== lvl) begin
            @(posedge sys_clk);
            cnt++;
            if (cnt > lim) bail("hold");
        end
    endtask : waitHold
    // one whole conversion; the trailing idle covers the post-conversion wait
    task automatic conv(input int c, input logic al, input logic [9:0] t);
        target <= t;
        apb(1'b1, ADDR_CLOCK_FORMAT, {24'h0, al, 4'h0, c[2:0]});
        apb(1'b1, ADDR_CONVERTER_CTRL, 32'h1);
        repeat (20) @(posedge sys_clk);
        apb(1'b1, ADDR_CONVERTER_CTRL, 32'h3);
        waitHold(1'b1, 8);
        waitHold(1'b0, 1000);
        check("hold length", cnt >= 12 * divs[c] - 1 && cnt <= 12 * divs[c] + 2, 1'b1);
        apb(1'b0, ADDR_CONVERTER_CTRL, 32'h0);
        check("go bit", rd[1], 1'b0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check("done flag", rd[0], 1'b1);
        apb(1'b0, ADDR_RESULT_HIGH, 32'h0);
        check("result high", rd, al ? {30'h0, t[9:8]} : {24'h0, t[9:2]});
        apb(1'b0, ADDR_RESULT_LOW, 32'h0);
        check("result low", rd, al ? {24'h0, t[7:0]} : {24'h0, t[1:0], 6'h0});
        check("irq set", irqRequest, 1'b1);
        apb(1'b1, ADDR_STATUS, 32'h3);
        @(posedge sys_clk);
        check("irq cleared", irqRequest, 1'b0);
        // two bit periods before the next go
        repeat (140) @(posedge sys_clk);
    endtask : conv
    // reset values, optionally after a reset that lands mid-conversion
    task automatic t_reset(input logic mid);
        logic [7:0] adrs[3] = '{ADDR_CONVERTER_CTRL, ADDR_PIN_REF_CFG, ADDR_CLOCK_FORMAT};
        if (mid) begin
            apb(1'b1, ADDR_CONVERTER_CTRL, 32'h3);
            waitHold(1'b1, 8);
            sys_rst <= 1'b1;
            repeat (2) @(posedge sys_clk);
            sys_rst <= 1'b0;
            @(posedge sys_clk);
            apb(1'b0, ADDR_RESULT_HIGH, 32'h0);
            check("result kept", rd, 32'hB0);
        end
        foreach (adrs[i]) begin
            apb(1'b0, adrs[i], 32'h0);
            check("reset value", rd, 32'h0);
        end
        check("pins analog", analogPinEnable, 16'hFFFF);
        check("hold idle", sampleHold, 1'b0);
        $display("test reset done");
    endtask : t_reset
    // field writes reach outputs; unused bits and unmapped address
    task automatic t_regs();
        apb(1'b1, ADDR_CLOCK_FORMAT, 32'hFF);
        apb(1'b0, ADDR_CLOCK_FORMAT, 32'h0);
        check("clock fmt", rd, 32'h87);
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, ADDR_CONVERTER_CTRL, i << 2);
            @(posedge sys_clk);
            check("channel", channelSelect, i);
            apb(1'b1, ADDR_PIN_REF_CFG, (i % 4) * 16 + i);
            @(posedge sys_clk);
            check("reference", referenceSelect, i % 4);
            check("analog pins", analogPinEnable, i == 0 ? 16'hFFFF : (16'h1 << (15 - i)) - 16'h1);
        end
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped", err, 1'b1);
        apb(1'b1, ADDR_PIN_REF_CFG, 32'h0);
        $display("test regs done");
    endtask : t_regs
    // every clock code once, alignment alternating, boundary results
    task automatic t_codes();
        apb(1'b1, ADDR_STATUS, 32'h2);
        for (int c = 0; c < 8; c++) begin
            conv(c, c[0], tgts[c]);
        end
        $display("test codes done");
    endtask : t_codes
    // go in the enabling write is dropped; oscillator codes stall in sleep
    task automatic t_sleep();
        apb(1'b1, ADDR_CONVERTER_CTRL, 32'h0);
        apb(1'b1, ADDR_CONVERTER_CTRL, 32'h3);
        repeat (4) @(posedge sys_clk);
        check("go with enable", sampleHold, 1'b0);
        apb(1'b1, ADDR_CLOCK_FORMAT, 32'h1);
        apb(1'b1, ADDR_CONVERTER_CTRL, 32'h3);
        waitHold(1'b1, 8);
        sleepMode <= 1'b1;
        repeat (120) @(posedge sys_clk);
        check("stalled", sampleHold, 1'b1);
        sleepMode <= 1'b0;
        waitHold(1'b0, 200);
        apb(1'b1, ADDR_STATUS, 32'h3);
        repeat (40) @(posedge sys_clk);
        sleepMode <= 1'b1;
        conv(3, 1'b0, 10'h2C3);
        sleepMode <= 1'b0;
        $display("test sleep done");
    endtask : t_sleep
    // clearing go mid-conversion keeps the old result, no done flag
    task automatic t_abort();
        target <= 10'h055;
        apb(1'b1, ADDR_CONVERTER_CTRL, 32'h3);
        waitHold(1'b1, 8);
        repeat (30) @(posedge sys_clk);
        apb(1'b1, ADDR_CONVERTER_CTRL, 32'h1);
        waitHold(1'b0, 4);
        apb(1'b0, ADDR_RESULT_LOW, 32'h0);
        check("kept low", rd, 32'hC0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check("no done", rd[0], 1'b0);
        repeat (40) @(posedge sys_clk);
        $display("test abort done");
    endtask : t_abort
    // main sequence
    initial begin
        sys_rst = 1'b1;
        clkEn = 1'b1;
        sleepMode = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        target = 10'h0;
        badCount = 0;
        checked = 0;
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        t_reset(1'b0);
        t_regs();
        t_codes();
        t_sleep();
        t_abort();
        t_reset(1'b1);
        finish_test();
    end
endmodule : test_sar_adc_sequencer
`default_nettype wire
